// ---- verilog/adc_conversion_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic IRQ_VECTOR_I,
    input wire logic ALE_I,
    output logic ALE_O,
    input wire logic CAPTURE_DONE_I,
    input wire logic CAPTURE_REQ_I,
    input wire logic [3:0] CAPTURE_CHANNEL_I,
    output logic CAPTURE_ENABLE_O,
    output logic ADC_START_O,
    output logic [3:0] ADC_CHANNEL_O,
    input wire logic ADC_DONE_I,
    input wire logic [11:0] ADC_RESULT_I,
    output logic [7:0] RESULT_HIGH_BYTE_O,
    output logic [7:0] RESULT_LOW_BYTE_O,
    output logic IRQ_O
);
    logic conversion_done_flag;
    logic capture_bit;
    logic continuous_convert_bit;
    logic single_convert_bit;
    logic [3:0] chan_field;
    logic [3:0] conv_chan;
    logic single_pending;
    logic done_d;
    conv_if cif ();

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    conv_sequencer u_seq (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .cif(cif),
        .adc_done_i(ADC_DONE_I),
        .adc_start_o(ADC_START_O),
        .adc_channel_o(ADC_CHANNEL_O)
    );

    ////////////////////////////////////////////////////////////////////////////
    // start requests

    always_comb begin
        conv_chan = capture_bit ? CAPTURE_CHANNEL_I : chan_field;
    end

    assign cif.start = !cif.busy &&
        ((capture_bit && CAPTURE_REQ_I) ||
         (!capture_bit && (continuous_convert_bit || single_pending)));
    assign cif.channel = conv_chan;

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            chan_field <= CTRL_RESET[CHAN_MSB:0];
            continuous_convert_bit <= CTRL_RESET[CONT_BIT];
        end else if (REG_WR_I) begin
            chan_field <= REG_WDATA_I[CHAN_MSB:0];
            continuous_convert_bit <= REG_WDATA_I[CONT_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            single_convert_bit <= CTRL_RESET[SINGLE_BIT];
            single_pending <= 1'b0;
        end else begin
            if (cif.start && single_pending) begin
                single_pending <= 1'b0;
            end
            if (REG_WR_I && REG_WDATA_I[SINGLE_BIT] && !single_convert_bit) begin
                single_convert_bit <= 1'b1;
                single_pending <= 1'b1;
            end else if (cif.done && single_convert_bit && !single_pending) begin
                single_convert_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            capture_bit <= CTRL_RESET[CAPTURE_BIT];
        end else if (REG_WR_I && REG_WDATA_I[CAPTURE_BIT]) begin
            capture_bit <= 1'b1;
        end else if (CAPTURE_DONE_I) begin
            capture_bit <= 1'b0;
        end
    end

    // set on single or capture end
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            conversion_done_flag <= CTRL_RESET[DONE_BIT];
        end else if ((cif.done && single_convert_bit && !single_pending) ||
                     (capture_bit && CAPTURE_DONE_I)) begin
            conversion_done_flag <= 1'b1;
        end else if (IRQ_VECTOR_I) begin
            conversion_done_flag <= 1'b0;
        end else if (REG_WR_I) begin
            conversion_done_flag <= REG_WDATA_I[DONE_BIT];
        end
    end

    assign REG_RDATA_O = {conversion_done_flag, capture_bit, continuous_convert_bit,
                          single_convert_bit, chan_field};
    assign CAPTURE_ENABLE_O = capture_bit;

    assign IRQ_O = conversion_done_flag;

    assign ALE_O = capture_bit ? 1'b0 : ALE_I;

    ////////////////////////////////////////////////////////////////////////////
    // result registers

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            RESULT_HIGH_BYTE_O <= 8'h00;
            RESULT_LOW_BYTE_O <= 8'h00;
            done_d <= 1'b0;
        end else begin
            done_d <= cif.done;
            if (cif.done) begin
                RESULT_HIGH_BYTE_O <= {ADC_CHANNEL_O, ADC_RESULT_I[11:8]};
                RESULT_LOW_BYTE_O <= ADC_RESULT_I[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence single_end_s;
        cif.done && single_convert_bit && !single_pending;
    endsequence

    sequence capture_end_s;
        capture_bit && CAPTURE_DONE_I;
    endsequence

    done_set_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        single_end_s |=> conversion_done_flag)
        else $error("done flag not set after single conversion");

    capture_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        capture_end_s |=> conversion_done_flag && !capture_bit)
        else $error("capture end not flagged");

    vector_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (IRQ_VECTOR_I && !cif.done && !CAPTURE_DONE_I) |=> !conversion_done_flag)
        else $error("vector did not clear done flag");

    capture_start_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (REG_WR_I && REG_WDATA_I[CAPTURE_BIT]) |=> CAPTURE_ENABLE_O)
        else $error("capture mode not started");

    ale_off_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        capture_bit |-> !ALE_O)
        else $error("strobe active during capture");

    // single launch, temperature channel waits out its acquisition first
    single_go_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (REG_WR_I && REG_WDATA_I[SINGLE_BIT] && !single_convert_bit && !capture_bit
         && !cif.busy && !continuous_convert_bit && !REG_WDATA_I[CAPTURE_BIT]
         && REG_WDATA_I[CHAN_MSB:0] != CHAN_TEMP) |=> ##[1:2] ADC_START_O)
        else $error("single conversion not launched");

    single_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (single_end_s and !(REG_WR_I && REG_WDATA_I[SINGLE_BIT])) |=> !single_convert_bit)
        else $error("single bit not cleared");

    result_tag_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        done_d |-> RESULT_HIGH_BYTE_O[7:4] == ADC_CHANNEL_O)
        else $error("result channel tag wrong");

    irq_level_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (IRQ_O && !IRQ_VECTOR_I && !REG_WR_I) |=> IRQ_O)
        else $error("interrupt request dropped while flag set");

    cont_restart_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (cif.done && continuous_convert_bit && !capture_bit && !REG_WR_I) |=> cif.start)
        else $error("continuous mode did not restart");
endmodule
`default_nettype wire

// ---- shared/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
    // register layout
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int DONE_BIT = 7;
    localparam int CAPTURE_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int SINGLE_BIT = 4;
    localparam int CHAN_MSB = 3;
    // channel codes
    localparam logic [3:0] CHAN_TEMP = 4'h8;
    localparam logic [3:0] CHAN_AGND = 4'hB;
    // temperature sensor acquisition, in ns, and its cycle count at 5 ns
    localparam int TEMP_ACQ_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TEMP_ACQ_CYC = (TEMP_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // converter sequencer states
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        ACQUIRE = 2'b01,
        CONVERT = 2'b10
    } conv_state_t;
endpackage

// ---- shared/conv_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface conv_if;
    logic start;
    logic [3:0] channel;
    logic done;
    logic busy;
    modport ctrl (output start, output channel, input done, input busy);
    modport seq (input start, input channel, output done, output busy);
endinterface
`default_nettype wire

// ---- verilog/conv_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer
    import adc_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    conv_if.seq cif,
    input wire logic adc_done_i,
    output logic adc_start_o,
    output logic [3:0] adc_channel_o
);
    conv_state_t state;
    logic [7:0] acq_cnt;

    // holds the channel, waits out temperature acquisition, then starts converter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= IDLE;
            acq_cnt <= 8'h00;
            adc_start_o <= 1'b0;
            adc_channel_o <= 4'h0;
        end else begin
            adc_start_o <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (cif.start) begin
                        adc_channel_o <= cif.channel;
                        acq_cnt <= (cif.channel == CHAN_TEMP) ? 8'(TEMP_ACQ_CYC) : 8'h00;
                        state <= ACQUIRE;
                    end
                end
                ACQUIRE: begin
                    if (acq_cnt == 8'h00) begin
                        adc_start_o <= 1'b1;
                        state <= CONVERT;
                    end else begin
                        acq_cnt <= acq_cnt - 8'h01;
                    end
                end
                CONVERT: begin
                    if (adc_done_i) begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    assign cif.done = (state == CONVERT) && adc_done_i;
    assign cif.busy = (state != IDLE);

    temp_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == IDLE && cif.start && cif.channel == CHAN_TEMP) |-> !adc_start_o [*8])
        else $error("temperature channel started too early");
endmodule
`default_nettype wire

// ---- test/adc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// behavioural converter: answers each start with one done pulse after lat cycles
module adc_model #(
    parameter int LAT = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] channel_i,
    output logic done_o,
    output logic [11:0] result_o
);
    int cnt;
    logic [11:0] held;
    // result carries the channel so the bench can tell conversions apart;
    // outside reset and the done cycle the data lines toggle, never hold a stale value
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        result_o <= ~result_o;
        if (rst_i) begin
            cnt <= 0;
            result_o <= 12'h000;
        end else if (start_i) begin
            cnt <= LAT;
            held <= {4'hC, channel_i, 4'h5};
        end else if (cnt == 1) begin
            cnt <= 0;
            done_o <= 1'b1;
            result_o <= held;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ---- test/adc_conversion_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_tb
    import adc_ctrl_pkg::*;
;
    logic clk, rst = 1'b1, wr = 1'b0, vec = 1'b0, ale = 1'b1;
    logic cap_done = 1'b0, cap_req = 1'b0, adc_done, ale_o, cap_en, adc_start, irq;
    logic [7:0] wdata = 8'h00, rdata, rhi, rlo;
    logic [3:0] cap_ch = 4'h0, adc_ch, last_ch;
    logic [11:0] adc_res;
    int num_errors = 0, n_tests = 0, starts = 0, s0, i;

    adc_conversion_control adc_conversion_control_i (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .IRQ_VECTOR_I(vec), .ALE_I(ale), .ALE_O(ale_o),
        .CAPTURE_DONE_I(cap_done), .CAPTURE_REQ_I(cap_req),
        .CAPTURE_CHANNEL_I(cap_ch), .CAPTURE_ENABLE_O(cap_en),
        .ADC_START_O(adc_start), .ADC_CHANNEL_O(adc_ch), .ADC_DONE_I(adc_done),
        .ADC_RESULT_I(adc_res), .RESULT_HIGH_BYTE_O(rhi), .RESULT_LOW_BYTE_O(rlo),
        .IRQ_O(irq)
    );
    adc_model adc_model_i (
        .clk_i(clk), .rst_i(rst), .start_i(adc_start), .channel_i(adc_ch),
        .done_o(adc_done), .result_o(adc_res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, start monitor, watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (adc_start === 1'b1) begin
            starts++;
            last_ch = adc_ch;
        end
    end
    initial begin
        #50000;
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // one-cycle pulse on capture done (cap=1) or interrupt vector (cap=0)
    task automatic pulse(input bit cap);
        @(posedge clk);
        if (cap) begin
            cap_done <= 1'b1;
        end else begin
            vec <= 1'b1;
        end
        @(posedge clk);
        cap_done <= 1'b0;
        vec <= 1'b0;
        #1;
    endtask
    task automatic wait_irq();
        i = 0;
        while (irq !== 1'b1 && i < 600) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk({7'h0, irq}, 8'h01); // flag raises request
    endtask
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(rdata, CTRL_RESET); // reset value
        chk({7'h0, irq}, 8'h00); // no request
        // single conversion on channel codes 0 to 11
        for (int c = 0; c < 12; c++) begin
            s0 = starts;
            wr_reg(8'h10 | 8'(c));
            wait_irq();
            chk(8'(i >= TEMP_ACQ_CYC), 8'(c == 8)); // temp acquisition wait
            repeat (3) @(posedge clk);
            #1;
            chk(8'(starts - s0), 8'h01); // one start
            chk({4'h0, last_ch}, 8'(c)); // channel used
            chk(rhi, {4'(c), 4'hC}); // channel in result
            chk(rlo, {4'(c), 4'h5}); // low byte of result
            chk(rdata, 8'h80 | 8'(c)); // single cleared
        end
        pulse(1'b0);
        chk(rdata, 8'h0B); // vector clears
        wr_reg(8'h12);
        wait_irq();
        wr_reg(8'h02);
        chk({rdata[7:4], 3'h0, irq}, 8'h00); // software clear
        // continuous conversion
        s0 = starts;
        wr_reg(8'h25);
        repeat (60) @(posedge clk);
        wr_reg(8'h05);
        chk({7'h0, (starts - s0) > 3}, 8'h01); // repeated starts
        chk({4'h0, last_ch}, 8'h05); // configured channel
        repeat (20) @(posedge clk);
        // capture mode
        wr_reg(8'h47);
        chk({6'h0, cap_en, ale_o}, 8'h02); // capture on, strobe off
        s0 = starts;
        @(posedge clk);
        cap_ch <= 4'h9;
        cap_req <= 1'b1;
        repeat (4) @(posedge clk);
        cap_req <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        chk({4'h0, last_ch}, 8'h09); // channel from memory
        chk({7'h0, starts > s0}, 8'h01); // capture converts
        pulse(1'b1);
        chk(rdata, 8'h87); // capture end
        chk({6'h0, cap_en, ale_o}, 8'h01); // strobe back
        @(posedge clk);
        ale <= 1'b0;
        #1;
        chk({7'h0, ale_o}, 8'h00); // strobe follows core
        conclude();
    end
endmodule
`default_nettype wire
